// ---- bls_pkg.sv ----
// constants, types and helpers shared by both ends of the backlight link
package bls_pkg;

  // ***********************************************************
  // clock and widths
  // ***********************************************************
  localparam int unsigned CLK_HZ  = 100_000_000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
  localparam int unsigned BRT_W   = 11;
  localparam int unsigned CNT_W   = 20;
  localparam int unsigned IDLE_W  = 22;
  localparam int unsigned PER_W   = 21;
  localparam int unsigned ACC_W   = 18;
  localparam logic [10:0] BRT_MAX = 11'h7ff;

  // ***********************************************************
  // device registers, fields and reset values
  // ***********************************************************
  localparam logic [7:0] REG_ENABLE = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h11;
  localparam logic [7:0] REG_BRT_HI = 8'h18;
  localparam logic [7:0] REG_BRT_LO = 8'h19;
  localparam int unsigned EN_CHIP_BIT  = 0;
  localparam int unsigned EN_SINK_LSB  = 1;
  localparam int unsigned CFG_EXP_BIT  = 7;
  localparam int unsigned CFG_MODE_LSB = 5;
  localparam int unsigned CFG_FILT_LSB = 3;
  localparam int unsigned CFG_RATE_LSB = 0;
  localparam logic [2:0] SINK_RST = 3'h7;
  localparam logic       CHIP_RST = 1'b1;
  localparam logic       EXP_RST  = 1'b0;
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [1:0] FILT_RST = 2'h1;
  localparam logic [1:0] RATE_RST = 2'h3;

  typedef enum logic [1:0] {
    BLS_MODE_I2C, BLS_MODE_PWM, BLS_MODE_MIX_A, BLS_MODE_MIX_B
  } bls_mode_e;

  // ***********************************************************
  // sampling, filter, timeout and pulse limits
  // ***********************************************************
  localparam logic [1:0] RATE_800K = 2'h0;
  localparam logic [1:0] RATE_4M   = 2'h1;
  localparam int unsigned SR_24M_KHZ  = 24000;
  localparam int unsigned SR_4M_KHZ   = 4000;
  localparam int unsigned SR_800K_KHZ = 800;
  localparam int unsigned GL0_NS = 15;
  localparam int unsigned GL1_NS = 100;
  localparam int unsigned GL2_NS = 150;
  localparam int unsigned GL3_NS = 200;
  localparam int unsigned TO_24M_US  = 600;
  localparam int unsigned TO_4M_US   = 3000;
  localparam int unsigned TO_800K_US = 25000;
  localparam int unsigned TO_24M_CYC  = TO_24M_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TO_4M_CYC   = TO_4M_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TO_800K_CYC = TO_800K_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MINP_24M_PS  = 183300;
  localparam int unsigned MINP_4M_PS   = 1100000;
  localparam int unsigned MINP_800K_PS = 5500000;
  localparam int unsigned CLK_PS = 1_000_000_000 / (CLK_HZ / 1000);
  localparam int unsigned PWM_MIN_HZ = 50;
  localparam int unsigned PWM_MAX_HZ = 50000;
  localparam logic [20:0] PER_MAX_CYC = 21'(CLK_HZ / PWM_MIN_HZ);
  localparam logic [20:0] PER_MIN_CYC = 21'(CLK_HZ / PWM_MAX_HZ);

  // ***********************************************************
  // host command port offsets
  // ***********************************************************
  localparam logic [3:0] H_CTRL   = 4'h0;
  localparam logic [3:0] H_PERIOD = 4'h1;
  localparam logic [3:0] H_HIGH   = 4'h2;
  localparam logic [3:0] H_DEVWR  = 4'h3;
  localparam logic [3:0] H_STATUS = 4'h4;

  // sample rate in kHz for a rate code
  function automatic logic [17:0] rate_khz(input logic [1:0] r);
    unique case (r)
      RATE_800K: rate_khz = 18'(SR_800K_KHZ);
      RATE_4M:   rate_khz = 18'(SR_4M_KHZ);
      default:   rate_khz = 18'(SR_24M_KHZ);
    endcase
  endfunction : rate_khz

  // stable cycles needed to accept a pwm level, never below one
  function automatic logic [4:0] glitch_cyc(input logic [1:0] f);
    int unsigned ns;
    unique case (f)
      2'h0:    ns = GL0_NS;
      2'h1:    ns = GL1_NS;
      2'h2:    ns = GL2_NS;
      default: ns = GL3_NS;
    endcase
    glitch_cyc = (ns * 1000 / CLK_PS < 1) ? 5'h01 : 5'(ns * 1000 / CLK_PS);
  endfunction : glitch_cyc

  // least pulse width in cycles, rounded up
  function automatic logic [20:0] min_pulse(input logic [1:0] r);
    int unsigned ps;
    unique case (r)
      RATE_800K: ps = MINP_800K_PS;
      RATE_4M:   ps = MINP_4M_PS;
      default:   ps = MINP_24M_PS;
    endcase
    min_pulse = 21'((ps + CLK_PS - 1) / CLK_PS);
  endfunction : min_pulse

endpackage : bls_pkg

// ---- bls_link_if.sv ----
// pins between the host and the backlight driver
`timescale 1ns/10ps
interface bls_link_if;
  logic       hardware_enable_pin;
  logic       backlight_adjust_input;
  logic       wr;
  logic [7:0] waddr;
  logic [7:0] wdata;

  modport dev (
    input hardware_enable_pin,
    input backlight_adjust_input,
    input wr,
    input waddr,
    input wdata
  );
  modport host (
    output hardware_enable_pin,
    output backlight_adjust_input,
    output wr,
    output waddr,
    output wdata
  );
endinterface : bls_link_if

// ---- bls_dev.sv ----
// driver end: enable control, pwm sampler and brightness code
`timescale 1ns/10ps

// Functional notes
// [RQ1] enable pin low resets registers, ignores writes
// [RQ2] enable pin high allows register writes
// [RQ3] three sink enables, all set after reset
// [RQ4] host sets chip enable, then pwm or code
// [RQ5] defaults: chip on, pwm on, linear
// [RQ6] standby watches pwm, duty becomes 11-bit code
// [RQ7] two-bit filter rejects short pwm glitches
// [RQ8] idle timeout depends on sample rate
// [RQ9] host keeps high pulses above minimum
// [RQ10] host keeps low pulses above minimum
// [RQ11] host keeps pwm between 50 Hz, 50 kHz
// [RQ12] 24 MHz sampling resolves 11 bits
// [RQ13] leds on well within 5 ms
// [RQ14] code zero off, higher codes more current
// [RQ15] pwm mode with pwm low stays standby
// [RQ16] duty from high versus total samples
// [RQ17] no edge within timeout returns standby; a steady high level gives full code instead
module bls_dev #(
  parameter int unsigned TO_24M  = bls_pkg::TO_24M_CYC,
  parameter int unsigned TO_4M   = bls_pkg::TO_4M_CYC,
  parameter int unsigned TO_800K = bls_pkg::TO_800K_CYC
) (
  bls_link_if.dev                         lnk,
  input  wire logic                       clk,
  input  wire logic                       rst,
  output logic [bls_pkg::BRT_W-1:0]       brightness_code,
  output logic [2:0]                      sink_enable,
  output logic                            mapping_exp,
  output logic                            led_on,
  output logic                            standby
);
  import bls_pkg::*;

  typedef enum logic [1:0] {ST_OFF, ST_STANDBY, ST_ACTIVE} bls_dst_e;

  typedef struct packed {
    logic              chip_en;
    logic [2:0]        sinks;
    logic              exp_map;
    logic [1:0]        bmode;
    logic [1:0]        filt;
    logic [1:0]        rate;
    logic [BRT_W-1:0]  brt;
    logic [ACC_W-1:0]  acc;
    logic              lvl;
    logic [4:0]        flt_cnt;
    logic [CNT_W-1:0]  hi_cnt;
    logic [CNT_W-1:0]  tot_cnt;
    logic              prd_ok;
    logic [IDLE_W-1:0] idle_cnt;
    logic              busy;
    logic [3:0]        div_cnt;
    logic [CNT_W:0]    rem;
    logic [CNT_W-1:0]  den;
    logic [BRT_W-1:0]  quo;
    logic [BRT_W-1:0]  pwm_code;
    logic [BRT_W-1:0]  out_code;
    logic              led;
    logic              stb;
    bls_dst_e          st;
  } bls_dev_s;

  bls_dev_s q, d;
  logic              ren;
  logic              edge_s;
  logic              rise_s;
  logic              tick_s;
  logic              tout_s;
  logic [ACC_W-1:0]  acc_sum;
  logic [IDLE_W-1:0] idle_lim;
  logic [CNT_W:0]    rem2;
  logic [21:0]       prod;
  logic [BRT_W-1:0]  sel_code;

  // timeout limit for the selected sample rate
  function automatic logic [IDLE_W-1:0] idle_limit(input logic [1:0] r);
    unique case (r)
      RATE_800K: idle_limit = IDLE_W'(TO_800K);
      RATE_4M:   idle_limit = IDLE_W'(TO_4M);
      default:   idle_limit = IDLE_W'(TO_24M);
    endcase
  endfunction : idle_limit

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb
  begin
    d        = q;
    idle_lim = idle_limit(q.rate);
    // register writes land only while the enable pin is high
    // [RQ2] accept register writes
    if (lnk.wr)
    begin
      unique case (lnk.waddr)
        REG_ENABLE:
        begin
          d.chip_en = lnk.wdata[EN_CHIP_BIT];
          // [RQ3] per sink enables
          d.sinks   = lnk.wdata[EN_SINK_LSB +: 3];
        end
        REG_CONFIG:
        begin
          d.exp_map = lnk.wdata[CFG_EXP_BIT];
          d.bmode   = lnk.wdata[CFG_MODE_LSB +: 2];
          d.filt    = lnk.wdata[CFG_FILT_LSB +: 2];
          d.rate    = lnk.wdata[CFG_RATE_LSB +: 2];
        end
        REG_BRT_HI: d.brt[10:8] = lnk.wdata[2:0];
        REG_BRT_LO: d.brt[7:0]  = lnk.wdata;
        default:    d.brt       = q.brt; // unmapped: ignored
      endcase
    end

    // [RQ7] accept a level only after it holds for the filter width
    if (lnk.backlight_adjust_input == q.lvl)
      d.flt_cnt = 5'h00;
    else if (q.flt_cnt + 5'h01 >= glitch_cyc(q.filt))
    begin
      d.lvl     = lnk.backlight_adjust_input;
      d.flt_cnt = 5'h00;
    end
    else
      d.flt_cnt = q.flt_cnt + 5'h01;
    edge_s = d.lvl != q.lvl;
    rise_s = d.lvl & ~q.lvl;

    // [RQ12] fractional accumulator gives the sample tick rate
    acc_sum = q.acc + rate_khz(q.rate);
    tick_s  = acc_sum >= ACC_W'(CLK_KHZ);
    d.acc   = tick_s ? acc_sum - ACC_W'(CLK_KHZ) : acc_sum;

    // [RQ16] count high and total samples over the period
    if (tick_s)
    begin
      d.tot_cnt = q.tot_cnt + 20'h00001;
      d.hi_cnt  = q.hi_cnt + {19'h00000, q.lvl};
    end

    // [RQ8] idle counter against the rate dependent limit
    tout_s = 1'b0;
    if (edge_s)
      d.idle_cnt = '0;
    else if (q.idle_cnt + 22'h000001 >= idle_lim)
    begin
      tout_s     = 1'b1;
      d.idle_cnt = '0;
    end
    else
      d.idle_cnt = q.idle_cnt + 22'h000001;

    // one bit of restoring division per cycle
    rem2 = {q.rem[CNT_W-1:0], 1'b0};
    if (q.busy)
    begin
      if (rem2 >= {1'b0, q.den})
      begin
        d.rem = rem2 - {1'b0, q.den};
        d.quo = {q.quo[BRT_W-2:0], 1'b1};
      end
      else
      begin
        d.rem = rem2;
        d.quo = {q.quo[BRT_W-2:0], 1'b0};
      end
      d.div_cnt = q.div_cnt - 4'h1;
      if (q.div_cnt == 4'h1)
      begin
        d.busy     = 1'b0;
        d.pwm_code = d.quo;
      end
    end

    // [RQ16] period closes on a rising edge: code = hi*2048/tot
    if (rise_s)
    begin
      if (q.prd_ok && q.tot_cnt != '0 && !q.busy)
      begin
        d.busy    = 1'b1;
        d.div_cnt = 4'(BRT_W);
        d.rem     = {1'b0, q.hi_cnt};
        d.den     = q.tot_cnt;
        d.quo     = '0;
      end
      d.prd_ok  = 1'b1;
      d.hi_cnt  = '0;
      d.tot_cnt = '0;
    end

    // [RQ17] no edge in time: steady level, full or zero duty
    if (tout_s)
    begin
      d.pwm_code = q.lvl ? BRT_MAX : '0;
      d.prd_ok   = 1'b0;
      d.busy     = 1'b0;
      d.hi_cnt   = '0;
      d.tot_cnt  = '0;
    end

    // code source chosen by brightness mode
    prod = q.brt * q.pwm_code;
    unique case (bls_mode_e'(q.bmode))
      BLS_MODE_I2C: sel_code = q.brt;
      BLS_MODE_PWM: sel_code = q.pwm_code;
      default:      sel_code = prod[21:11];
    endcase

    // [RQ14] zero code gives no current, standby
    // [RQ15] pwm mode with idle low pwm stays in standby
    // [RQ13] code reaches the sinks in a few cycles
    if (!q.chip_en)
      d.st = ST_OFF;
    else if (q.sinks != 3'h0 && sel_code != '0)
      d.st = ST_ACTIVE;
    else
      d.st = ST_STANDBY;
    d.led      = (d.st == ST_ACTIVE);
    // [RQ6] standby flag registered with the state
    d.stb      = (d.st == ST_STANDBY);
    d.out_code = d.led ? sel_code : '0;
  end

  // ***********************************************************
  // state register
  // ***********************************************************
  // [RQ1] enable pin low holds everything at default
  assign ren = rst | ~lnk.hardware_enable_pin;

  always_ff @(posedge clk)
  begin
    if (ren)
    begin
      q         <= '0;
      // [RQ5] stand-alone defaults
      q.chip_en <= CHIP_RST;
      q.sinks   <= SINK_RST;
      q.exp_map <= EXP_RST;
      q.bmode   <= MODE_RST;
      q.filt    <= FILT_RST;
      q.rate    <= RATE_RST;
      q.st      <= ST_OFF;
    end
    else
      q <= d;
  end

  // outputs straight from the state register
  assign brightness_code = q.out_code;
  assign sink_enable     = q.sinks;
  assign mapping_exp     = q.exp_map;
  assign led_on          = q.led;
  // [RQ6] standby while waiting for nonzero duty
  assign standby         = q.stb;

endmodule : bls_dev

// ---- bls_host.sv ----
// host end: enable pin, pwm generator and register writes
`timescale 1ns/10ps
module bls_host (
  bls_link_if.host         lnk,
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [31:0]      sw_rdata
);
  import bls_pkg::*;

  typedef struct packed {
    logic        hw_en;
    logic        run;
    logic [20:0] period;
    logic [20:0] high;
    logic [1:0]  rate;
    logic [20:0] cnt;
    logic        pwm;
    logic        wr;
    logic [7:0]  waddr;
    logic [7:0]  wdata;
    logic [31:0] rdata;
  } bls_host_s;

  bls_host_s   q, d;
  logic [20:0] minp;
  logic [20:0] hi_eff;
  logic [20:0] per_in;

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb
  begin
    d       = q;
    d.wr    = 1'b0;
    d.rdata = '0;
    minp    = min_pulse(q.rate);
    per_in  = sw_wdata[20:0];
    if (sw_wr)
    begin
      unique case (sw_addr)
        H_CTRL:
        begin
          d.hw_en = sw_wdata[0];
          d.run   = sw_wdata[1];
        end
        // [RQ11] period kept inside 50 Hz to 50 kHz
        H_PERIOD:
          d.period = (per_in < PER_MIN_CYC) ? PER_MIN_CYC :
                     (per_in > PER_MAX_CYC) ? PER_MAX_CYC : per_in;
        H_HIGH: d.high = sw_wdata[20:0];
        // [RQ4] forward register writes, chip enable among them
        H_DEVWR:
          if (q.hw_en)
          begin
            d.wr    = 1'b1;
            d.waddr = sw_wdata[15:8];
            d.wdata = sw_wdata[7:0];
            if (sw_wdata[15:8] == REG_CONFIG)
              d.rate = sw_wdata[CFG_RATE_LSB +: 2];
          end
        default: d.rdata = '0; // unmapped: ignored
      endcase
    end
    // device drops to defaults with the pin, so does the shadow
    if (!d.hw_en)
      d.rate = RATE_RST;
    if (sw_rd)
    begin
      unique case (sw_addr)
        H_CTRL:   d.rdata = {30'h0, q.run, q.hw_en};
        H_PERIOD: d.rdata = {11'h0, q.period};
        H_HIGH:   d.rdata = {11'h0, q.high};
        H_STATUS: d.rdata = {28'h0, q.rate, q.pwm, q.hw_en};
        default:  d.rdata = '0;
      endcase
    end

    // [RQ9] high pulses stretched to the least width
    // [RQ10] short low pulses folded into full duty
    if (q.high == '0)
      hi_eff = '0;
    else if (q.high < minp)
      hi_eff = minp;
    else
      hi_eff = q.high;
    if (hi_eff + minp > q.period)
      hi_eff = (q.high == '0) ? 21'h0 : q.period;

    // free running period counter
    if (!q.run)
    begin
      d.cnt = '0;
      d.pwm = 1'b0;
    end
    else
    begin
      d.cnt = (q.cnt + 21'h1 >= q.period) ? 21'h0 : q.cnt + 21'h1;
      d.pwm = d.cnt < hi_eff;
    end
  end

  // ***********************************************************
  // state register
  // ***********************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q        <= '0;
      q.period <= PER_MIN_CYC;
      q.rate   <= RATE_RST;
    end
    else
      q <= d;
  end

  // pins and read data from the state register
  assign lnk.hardware_enable_pin    = q.hw_en;
  assign lnk.backlight_adjust_input = q.pwm;
  assign lnk.wr                     = q.wr;
  assign lnk.waddr                  = q.waddr;
  assign lnk.wdata                  = q.wdata;
  assign sw_rdata                   = q.rdata;

endmodule : bls_host

// ---- bls_props.sv ----
// concurrent checks on the host to driver link and driver outputs
`timescale 1ns/10ps
module bls_props #(
  parameter int unsigned TO_24M  = 6000,
  parameter int unsigned TO_4M   = 8000,
  parameter int unsigned TO_800K = 10000
) (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      hardware_enable_pin,
  input wire logic                      backlight_adjust_input,
  input wire logic                      wr,
  input wire logic [7:0]                waddr,
  input wire logic [7:0]                wdata,
  input wire logic [bls_pkg::BRT_W-1:0] brightness_code,
  input wire logic [2:0]                sink_enable,
  input wire logic                      mapping_exp,
  input wire logic                      led_on,
  input wire logic                      standby
);
  import bls_pkg::*;
  // ***********************************************************
  // register mirror and idle level counter
  // ***********************************************************
  localparam int unsigned SLK = 40;
  logic [7:0]  cfg_q;
  logic [3:0]  en_q;
  logic [7:0]  wd_q;
  logic        adj_q;
  int unsigned lvl_q;
  int unsigned lim;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // mirror writes the driver may take; count cycles of a steady pwm level
  always_ff @(posedge clk)
  begin
    adj_q <= backlight_adjust_input;
    if (wr)
      wd_q <= wdata;
    if (rst || !hardware_enable_pin)
    begin
      cfg_q <= {EXP_RST, MODE_RST, FILT_RST, 1'b0, RATE_RST};
      en_q  <= {SINK_RST, CHIP_RST};
      lvl_q <= 0;
    end
    else
    begin
      if (wr && waddr == REG_CONFIG)
        cfg_q <= wdata;
      if (wr && waddr == REG_ENABLE)
        en_q <= wdata[3:0];
      if (adj_q != backlight_adjust_input || (wr && waddr == REG_CONFIG))
        lvl_q <= 0;
      else
        lvl_q <= lvl_q + 1;
    end
  end

  // idle limit of the mirrored sample rate
  always_comb
  begin
    case (cfg_q[1:0])
      RATE_800K: lim = TO_800K;
      RATE_4M:   lim = TO_4M;
      default:   lim = TO_24M;
    endcase
  end

  // ***********************************************************
  // properties
  // ***********************************************************
  sequence s_dev_wr(logic [7:0] a);
    wr && waddr == a && hardware_enable_pin
      ##1 (hardware_enable_pin && !wr)[*3];
  endsequence
  sequence s_rise;
    $rose(hardware_enable_pin) ##1 (hardware_enable_pin && !wr)[*3];
  endsequence
  property p_off_reset;
    !hardware_enable_pin |=> brightness_code == '0 && !led_on && !standby
      && sink_enable == SINK_RST && mapping_exp == EXP_RST;
  endproperty
  property p_defaults;
    $rose(hardware_enable_pin) |-> sink_enable == SINK_RST && !mapping_exp;
  endproperty
  property p_start_standby;
    s_rise |-> standby && !led_on;
  endproperty
  property p_sink_wr;
    s_dev_wr(REG_ENABLE) |-> sink_enable == wd_q[3:1];
  endproperty
  property p_exp_wr;
    s_dev_wr(REG_CONFIG) |-> mapping_exp == wd_q[7];
  endproperty
  property p_code_led;
    led_on == (brightness_code != '0) && !(led_on && standby);
  endproperty
  property p_chip_off;
    (!en_q[0])[*3] |-> !led_on && !standby;
  endproperty
  property p_sink_zero;
    (en_q[0] && en_q[3:1] == 3'h0)[*3] |-> standby && !led_on;
  endproperty
  property p_idle_low;
    lvl_q == lim + SLK && !backlight_adjust_input && cfg_q[6:5] != 2'h0
      |-> !led_on && brightness_code == '0;
  endproperty
  property p_idle_high;
    lvl_q == lim + SLK && backlight_adjust_input && cfg_q[6:5] == 2'h1
      && en_q[0] && en_q[3:1] != 3'h0 |-> led_on && brightness_code == BRT_MAX;
  endproperty

  a_off_reset: assert property (p_off_reset)
    else $error("outputs not at reset values with enable pin low");
  a_defaults: assert property (p_defaults)
    else $error("sink or mapping default wrong after enable");
  a_start_standby: assert property (p_start_standby)
    else $error("no standby after enable pin rise");
  a_sink_wr: assert property (p_sink_wr)
    else $error("sink enables do not follow write");
  a_exp_wr: assert property (p_exp_wr)
    else $error("mapping select does not follow write");
  a_code_led: assert property (p_code_led)
    else $error("led state and code disagree");
  a_chip_off: assert property (p_chip_off)
    else $error("driver not off with chip enable clear");
  a_sink_zero: assert property (p_sink_zero)
    else $error("no standby with all sinks disabled");
  a_idle_low: assert property (p_idle_low)
    else $error("leds still on after idle low timeout");
  a_idle_high: assert property (p_idle_high)
    else $error("leds not full after idle high timeout");
endmodule : bls_props

// ---- backlight_enable_pwm_sampler_tb.sv ----
// bench: host and driver joined, plus a driver fed directly
`timescale 1ns/10ps
module backlight_enable_pwm_sampler_tb;
  import bls_pkg::*;
  // ***********************************************************
  // clock, links and both ends
  // ***********************************************************
  localparam int unsigned T24 = 6000;
  localparam int unsigned T4  = 8000;
  localparam int unsigned T08 = 10000;
  logic             clk;
  logic             rst;
  logic [3:0]       sw_addr;
  logic [31:0]      sw_wdata, sw_rdata, rd;
  logic             sw_wr, sw_rd, ok;
  logic [BRT_W-1:0] code1, code2, rc;
  logic [2:0]       sink1, sink2;
  logic             exp1, exp2, led1, led2, stb1, stb2;
  int               err_count = 0, check_count = 0, cyc = 0;
  int               per, hi, expc, tol;
  int               nf [4] = '{1, 10, 15, 20};
  bls_link_if lk1 ();
  bls_link_if lk2 ();
  bls_host u_bls_host (.lnk(lk1), .clk(clk), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  bls_dev #(.TO_24M(T24), .TO_4M(T4), .TO_800K(T08)) u_bls_dev (.lnk(lk1),
    .clk(clk), .rst(rst), .brightness_code(code1), .sink_enable(sink1),
    .mapping_exp(exp1), .led_on(led1), .standby(stb1));
  bls_dev #(.TO_24M(T24), .TO_4M(T4), .TO_800K(T08)) u_bls_dev_b (.lnk(lk2),
    .clk(clk), .rst(rst), .brightness_code(code2), .sink_enable(sink2),
    .mapping_exp(exp2), .led_on(led2), .standby(stb2));
  bls_props #(.TO_24M(T24), .TO_4M(T4), .TO_800K(T08)) u_bls_props (
    .clk(clk), .rst(rst), .hardware_enable_pin(lk1.hardware_enable_pin),
    .backlight_adjust_input(lk1.backlight_adjust_input), .wr(lk1.wr),
    .waddr(lk1.waddr), .wdata(lk1.wdata), .brightness_code(code1),
    .sink_enable(sink1), .mapping_exp(exp1), .led_on(led1), .standby(stb1));

  // free running clock
  always #5 clk = ~clk;

  // cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      err_count++;
      wrap_up();
    end
  end

  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_addr <= ~a;
    sw_wdata <= ~d;
  endtask : sw_write
  task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'b0;
    sw_addr <= ~a;
    @(posedge clk);
    d = sw_rdata;
  endtask : sw_read
  // device write through the host
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    sw_write(H_DEVWR, {16'h0, a, d});
    tick(5);
  endtask : dwr
  // config write driven straight onto the second link
  task automatic d2_cfg(input logic [7:0] d);
    @(posedge clk);
    lk2.wr <= 1'b1;
    lk2.waddr <= REG_CONFIG;
    lk2.wdata <= d;
    @(posedge clk);
    lk2.wr <= 1'b0;
    lk2.waddr <= ~REG_CONFIG;
    lk2.wdata <= ~d;
  endtask : d2_cfg
  // two pwm pulses of width w in 2000-cycle periods
  task automatic d2_pulses(input int w);
    repeat (2)
    begin
      lk2.backlight_adjust_input <= 1'b1;
      tick(w);
      lk2.backlight_adjust_input <= 1'b0;
      tick(2000 - w);
    end
  endtask : d2_pulses

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
    {lk2.hardware_enable_pin, lk2.backlight_adjust_input} = 2'b00;
    {lk2.wr, lk2.waddr, lk2.wdata} = '0;
    void'($urandom(12));
    tick(16);
    rst <= 1'b0;
    tick(3);
    check("off", {led1, stb1, exp1, sink1, code1}, {3'h0, 3'h7, 11'h0});
    sw_write(H_CTRL, 32'h1);
    tick(6);
    check("start", {led1, stb1, exp1, sink1, code1}, {3'h2, 3'h7, 11'h0});
    sw_read(H_STATUS, rd);
    check("status", rd[1:0], 2'h1);
    sw_read(4'hf, rd);
    check("unmapped", rd, 32'h0);
    // brightness from the written code, exponential mapping
    rc = 11'($urandom_range(1, 2047));
    dwr(REG_CONFIG, 8'h8b);
    dwr(REG_BRT_HI, {5'h0, rc[10:8]});
    dwr(REG_BRT_LO, rc[7:0]);
    check("i2c", {led1, stb1, exp1, code1}, {3'h5, rc});
    // product mode with no pwm duty yet gives a zero code
    dwr(REG_CONFIG, 8'h4b);
    check("mix", {led1, stb1}, 2'h1);
    dwr(REG_BRT_HI, 8'h0);
    dwr(REG_BRT_LO, 8'h0);
    check("zero", {led1, stb1, code1}, {2'h1, 11'h0});
    dwr(REG_BRT_LO, 8'h5);
    dwr(REG_ENABLE, 8'h01);
    check("nosink", {led1, stb1, sink1}, {2'h1, 3'h0});
    dwr(REG_ENABLE, 8'h00);
    check("chipoff", {led1, stb1}, 2'h0);
    dwr(REG_ENABLE, 8'h0f);
    dwr(REG_CONFIG, 8'h2b);
    // duty cycle against the model
    for (int i = 0; i < 3; i++)
    begin
      per = $urandom_range(2400, 3200);
      hi = $urandom_range(60, per - 60);
      sw_write(H_PERIOD, 32'(per));
      sw_write(H_HIGH, 32'(hi));
      sw_write(H_CTRL, 32'h3);
      tick(3 * per + 40);
      expc = hi * 2048 / per;
      tol = 2 * 2048 * 100 / (per * 24) + 2;
      ok = (32'(code1) + tol >= expc) && (32'(code1) <= expc + tol);
      check("pwm", {ok, led1}, 2'h3);
    end
    // idle timeout at the 4 MHz rate
    dwr(REG_CONFIG, 8'h29);
    sw_write(H_CTRL, 32'h1);
    tick(T4 - per - 60);
    check("hold", led1, 1'b1);
    tick(per + 120);
    check("idle", {led1, stb1, code1}, {2'h1, 11'h0});
    sw_write(H_CTRL, 32'h0);
    tick(3);
    check("reoff", {led1, stb1, exp1, sink1, code1}, {3'h0, 3'h7, 11'h0});
    // enable with pwm held high
    sw_write(H_PERIOD, 32'd2000);
    sw_write(H_HIGH, 32'd2000);
    sw_write(H_CTRL, 32'h3);
    tick(T24 * 9 / 10);
    check("early", {led1, stb1}, 2'h1);
    tick(T24 / 10 + 60);
    check("full", {led1, code1}, {1'b1, BRT_MAX});
    // glitch filter settings on the directly driven driver
    for (int f = 0; f < 4; f++)
    begin
      lk2.hardware_enable_pin <= 1'b0;
      tick(2);
      lk2.hardware_enable_pin <= 1'b1;
      d2_cfg(8'h23 | 8'(f << 3));
      if (f > 0)
      begin
        d2_pulses(nf[f] - 1);
        check("drop", {led2, stb2}, 2'h1);
      end
      d2_pulses(nf[f] + 25);
      check("pass", {led2, exp2, sink2}, {2'b10, 3'h7});
    end
    wrap_up();
  end
endmodule : backlight_enable_pwm_sampler_tb
